//--- rtl/sfs_defs.svh
`ifndef SFS_DEFS_SVH
`define SFS_DEFS_SVH
`define SFS_OP_PGM_SEC 8'h9b
`define SFS_OP_PGM_FILL 8'h00
`define SFS_OP_RD_SEC 8'h77
`define SFS_OP_XFER1 8'h53
`define SFS_OP_XFER2 8'h55
`define SFS_OP_CMP1 8'h60
`define SFS_OP_CMP2 8'h61
`define SFS_OP_RWR1 8'h58
`define SFS_OP_RWR2 8'h59
`define SFS_OP_STATUS 8'hd7
`define SFS_HDR_BYTES 9'h004
`define SFS_STAT_BYTES 9'h001
`define SFS_SEC_LEN 9'h080
`define SFS_OTP_LEN 9'h040
`define SFS_PAGE_STD 9'h108
`define SFS_PAGE_BIN 9'h100
`define SFS_BUF_WORDS 264
`define SFS_OTP_WORDS 64
`define SFS_IDX_MAX 9'h1ff
`define SFS_LAST_BIT 3'h7
`define SFS_LAST_PTR 6'h3f
`define SFS_ERASED 8'hff
`define SFS_DENSITY 4'h9
`define SFS_PROTECT 1'h0
`define SFS_ST_RDY 7
`define SFS_ST_COMP 6
`define SFS_FIFO_DEPTH 32
`define SFS_FIFO_WIDTH 14
// Pattern seeds for the modelled array and factory area; values are arbitrary.
`define SFS_MAIN_SEED 8'h5a
`define SFS_UID_SEED 8'hc3
`define SFS_CLK_PERIOD_NS 100
`define SFS_NS_PER_US 1000
`define SFS_PROGRAM_TIME_US 4000
`define SFS_PAGE_MOVE_TIME_US 200
`define SFS_MATCH_CHECK_TIME_US 200
`define SFS_REWRITE_TIME_US 4000
`endif

//--- rtl/sfs_pkg.sv
package sfs_pkg;
  typedef enum logic [1:0] {
    SFS_ST_IDLE = 2'h0,
    SFS_ST_DRAIN = 2'h1,
    SFS_ST_LOOP = 2'h3,
    SFS_ST_WAIT = 2'h2
  } sfs_state_t;
  typedef enum logic [1:0] {
    SFS_K_XFER = 2'h0,
    SFS_K_CMP = 2'h1,
    SFS_K_RWR = 2'h2,
    SFS_K_PGM = 2'h3
  } sfs_kind_t;
endpackage

//--- rtl/sfs_top.sv
`timescale 1ns/10ps
`include "sfs_defs.svh"

// ======================================================================
// Stream FIFO
module sfs_fifo #(
  parameter int WIDTH = `SFS_FIFO_WIDTH,
  parameter int DEPTH = `SFS_FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_reg;
  logic [AW:0] rp_reg;
  logic full;
  logic empty;

  assign full = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
  assign empty = (wp_reg == rp_reg);
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem[rp_reg[AW-1:0]];

  always_ff @(posedge clk_in) begin
    if (in_valid_in && !full) begin
      mem[wp_reg[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (in_valid_in && !full) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (out_ready_in && !empty) begin
        rp_reg <= rp_reg + 1'b1;
      end
    end
  end
endmodule

// ======================================================================
// Command sequencer
module sfs_top
  import sfs_pkg::*;
#(
  parameter int unsigned PGM_CYC = `SFS_PROGRAM_TIME_US * `SFS_NS_PER_US / `SFS_CLK_PERIOD_NS,
  parameter int unsigned XFER_CYC = `SFS_PAGE_MOVE_TIME_US * `SFS_NS_PER_US / `SFS_CLK_PERIOD_NS,
  parameter int unsigned CMP_CYC = `SFS_MATCH_CHECK_TIME_US * `SFS_NS_PER_US / `SFS_CLK_PERIOD_NS,
  parameter int unsigned RWR_CYC = `SFS_REWRITE_TIME_US * `SFS_NS_PER_US / `SFS_CLK_PERIOD_NS
) (
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  input wire logic CS_N_IN,
  input wire logic SCK_IN,
  input wire logic SI_IN,
  input wire logic PAGE_256_IN,
  output logic SO_OUT,
  output logic SO_OE_OUT
);
  function automatic logic [7:0] page_byte(input logic [11:0] pg, input logic [8:0] i);
    page_byte = pg[7:0] ^ pg[11:4] ^ i[7:0] ^ `SFS_MAIN_SEED;
  endfunction

  function automatic logic [7:0] factory_byte(input logic [5:0] i);
    factory_byte = {2'h0, i} ^ `SFS_UID_SEED;
  endfunction

  function automatic logic [11:0] page_of(input logic [23:0] a, input logic bin);
    page_of = bin ? a[19:8] : a[20:9];
  endfunction

  // ======================================================================
  // Pin synchronisers
  logic cs_m_reg, cs_s_reg, cs_d_reg;
  logic sck_m_reg, sck_s_reg, sck_d_reg;
  logic si_m_reg, si_s_reg;
  logic ps_m_reg, ps_s_reg;

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      cs_m_reg <= 1'b1;
      cs_s_reg <= 1'b1;
      cs_d_reg <= 1'b1;
      sck_m_reg <= 1'b0;
      sck_s_reg <= 1'b0;
      sck_d_reg <= 1'b0;
      si_m_reg <= 1'b0;
      si_s_reg <= 1'b0;
      ps_m_reg <= 1'b0;
      ps_s_reg <= 1'b0;
    end else begin
      cs_m_reg <= CS_N_IN;
      cs_s_reg <= cs_m_reg;
      cs_d_reg <= cs_s_reg;
      sck_m_reg <= SCK_IN;
      sck_s_reg <= sck_m_reg;
      sck_d_reg <= sck_s_reg;
      si_m_reg <= SI_IN;
      si_s_reg <= si_m_reg;
      ps_m_reg <= PAGE_256_IN;
      ps_s_reg <= ps_m_reg;
    end
  end

  logic cs_rise, sck_rise, sck_fall, byte_done;
  logic [7:0] byte_val;
  logic [2:0] bit_cnt_reg;
  logic [8:0] byte_idx_reg;
  logic [6:0] sh_reg;
  logic [7:0] opcode_reg;
  logic [23:0] addr_reg;
  logic hdr_ok_reg;

  assign cs_rise = cs_s_reg && !cs_d_reg;
  assign sck_rise = !cs_s_reg && sck_s_reg && !sck_d_reg;
  assign sck_fall = !cs_s_reg && !sck_s_reg && sck_d_reg;
  assign byte_done = sck_rise && (bit_cnt_reg == `SFS_LAST_BIT);
  assign byte_val = {sh_reg, si_s_reg};

  // ======================================================================
  // Serial input: MSB first on rising clock.
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      bit_cnt_reg <= 3'h0;
      byte_idx_reg <= 9'h000;
      sh_reg <= 7'h00;
      opcode_reg <= 8'h00;
      addr_reg <= 24'h000000;
      hdr_ok_reg <= 1'b0;
    end else if (cs_s_reg) begin
      bit_cnt_reg <= 3'h0;
      byte_idx_reg <= 9'h000;
    end else if (sck_rise) begin
      sh_reg <= byte_val[6:0];
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (byte_done) begin
        if (byte_idx_reg != `SFS_IDX_MAX) begin
          byte_idx_reg <= byte_idx_reg + 9'h001;
        end
        if (byte_idx_reg == 9'h000) begin
          opcode_reg <= byte_val;
          hdr_ok_reg <= 1'b1;
        end else if (byte_idx_reg < `SFS_HDR_BYTES) begin
          addr_reg <= {addr_reg[15:0], byte_val};
          if (byte_val != `SFS_OP_PGM_FILL) begin
            hdr_ok_reg <= 1'b0;
          end
        end
      end
    end
  end

  // ======================================================================
  // Operation engine state
  sfs_state_t state_reg;
  sfs_kind_t kind_reg;
  logic sel2_reg, comp_reg, mismatch_reg, otp_used_reg;
  logic [11:0] page_reg;
  logic [8:0] eidx_reg, len;
  logic [19:0] timer_reg;
  logic busy, page_hdr, is_page_op;
  logic [7:0] status_w, buf_rd, pb;
  logic [7:0] buf1_mem [`SFS_BUF_WORDS];
  logic [7:0] buf2_mem [`SFS_BUF_WORDS];
  logic [7:0] otp_mem [`SFS_OTP_WORDS];

  assign busy = (state_reg != SFS_ST_IDLE);
  assign status_w = {!busy, comp_reg, `SFS_DENSITY, `SFS_PROTECT, ps_s_reg};
  assign page_hdr = (byte_idx_reg >= `SFS_HDR_BYTES) && (bit_cnt_reg == 3'h0);
  assign is_page_op = (opcode_reg == `SFS_OP_XFER1) || (opcode_reg == `SFS_OP_XFER2) ||
                      (opcode_reg == `SFS_OP_CMP1) || (opcode_reg == `SFS_OP_CMP2) ||
                      (opcode_reg == `SFS_OP_RWR1) || (opcode_reg == `SFS_OP_RWR2);
  assign len = (kind_reg == SFS_K_PGM) ? `SFS_OTP_LEN :
               (ps_s_reg ? `SFS_PAGE_BIN : `SFS_PAGE_STD);
  assign buf_rd = sel2_reg ? buf2_mem[eidx_reg] : buf1_mem[eidx_reg];
  assign pb = page_byte(page_reg, eidx_reg);

  // ======================================================================
  // Program data stream into buffer 1
  logic push, push_ok, fifo_in_ready, fifo_out_valid, drain;
  logic [5:0] wr_ptr_reg;
  logic [13:0] fifo_out;

  assign push = byte_done && (opcode_reg == `SFS_OP_PGM_SEC) && hdr_ok_reg &&
                (byte_idx_reg >= `SFS_HDR_BYTES) && !busy;
  assign push_ok = push && fifo_in_ready;
  assign drain = fifo_out_valid && ((state_reg == SFS_ST_IDLE) || (state_reg == SFS_ST_DRAIN));

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN || cs_s_reg) begin
      wr_ptr_reg <= 6'h00;
    end else if (push_ok) begin
      wr_ptr_reg <= wr_ptr_reg + 6'h01;
    end
  end

  sfs_fifo #(.WIDTH(`SFS_FIFO_WIDTH), .DEPTH(`SFS_FIFO_DEPTH)) u_fifo (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(RST_N_IN),
    .in_valid_in(push),
    .in_ready_out(fifo_in_ready),
    .in_data_in({wr_ptr_reg, byte_val}),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(drain),
    .out_data_out(fifo_out)
  );

  // Buffer storage; a drained byte lands at its wrapped pointer.
  always_ff @(posedge CLK_SYS_IN) begin
    if (drain) begin
      buf1_mem[{3'h0, fifo_out[13:8]}] <= fifo_out[7:0];
    end
    if ((state_reg == SFS_ST_LOOP) && ((kind_reg == SFS_K_XFER) || (kind_reg == SFS_K_RWR))) begin
      if (sel2_reg) begin
        buf2_mem[eidx_reg] <= pb;
      end else begin
        buf1_mem[eidx_reg] <= pb;
      end
    end
  end

  // Unsent user bytes take whatever buffer 1 held, which is undefined to the user.
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      for (int i = 0; i < `SFS_OTP_WORDS; i++) begin
        otp_mem[i] <= `SFS_ERASED;
      end
    end else if ((state_reg == SFS_ST_LOOP) && (kind_reg == SFS_K_PGM)) begin
      otp_mem[eidx_reg[5:0]] <= buf1_mem[eidx_reg];
    end
  end

  // ======================================================================
  // Engine sequencing
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      state_reg <= SFS_ST_IDLE;
      kind_reg <= SFS_K_XFER;
      sel2_reg <= 1'b0;
      page_reg <= 12'h000;
      eidx_reg <= 9'h000;
      timer_reg <= 20'h00000;
      mismatch_reg <= 1'b0;
      comp_reg <= 1'b0;
      otp_used_reg <= 1'b0;
    end else begin
      if (busy && (timer_reg != 20'h00000)) begin
        timer_reg <= timer_reg - 20'h00001;
      end
      case (state_reg)
        SFS_ST_IDLE: begin
          eidx_reg <= 9'h000;
          mismatch_reg <= 1'b0;
          page_reg <= page_of(addr_reg, ps_s_reg);
          if (cs_rise && page_hdr && is_page_op) begin
            state_reg <= SFS_ST_LOOP;
            sel2_reg <= (opcode_reg == `SFS_OP_XFER2) || (opcode_reg == `SFS_OP_CMP2) ||
                        (opcode_reg == `SFS_OP_RWR2);
            if (opcode_reg[5]) begin
              kind_reg <= SFS_K_CMP;
              timer_reg <= CMP_CYC[19:0];
            end else if (opcode_reg[3]) begin
              kind_reg <= SFS_K_RWR;
              timer_reg <= RWR_CYC[19:0];
            end else begin
              kind_reg <= SFS_K_XFER;
              timer_reg <= XFER_CYC[19:0];
            end
          end else if (cs_rise && page_hdr && hdr_ok_reg && !otp_used_reg &&
                       (opcode_reg == `SFS_OP_PGM_SEC)) begin
            state_reg <= SFS_ST_DRAIN;
            kind_reg <= SFS_K_PGM;
            sel2_reg <= 1'b0;
            otp_used_reg <= 1'b1;
            timer_reg <= PGM_CYC[19:0];
          end
        end
        SFS_ST_DRAIN: begin
          if (!fifo_out_valid) begin
            state_reg <= SFS_ST_LOOP;
          end
        end
        SFS_ST_LOOP: begin
          if ((kind_reg == SFS_K_CMP) && (buf_rd != pb)) begin
            mismatch_reg <= 1'b1;
          end
          if (eidx_reg == len - 9'h001) begin
            state_reg <= SFS_ST_WAIT;
          end else begin
            eidx_reg <= eidx_reg + 9'h001;
          end
        end
        SFS_ST_WAIT: begin
          if (timer_reg == 20'h00000) begin
            state_reg <= SFS_ST_IDLE;
            if (kind_reg == SFS_K_CMP) begin
              comp_reg <= mismatch_reg;
            end
          end
        end
        default: begin
          state_reg <= SFS_ST_IDLE;
        end
      endcase
    end
  end

  // ======================================================================
  // Serial output: launched on falling clock, released on deselect.
  logic rd_stat, rd_sec;
  logic [8:0] sec_idx;
  logic [7:0] sec_byte, out_byte;

  assign rd_stat = (opcode_reg == `SFS_OP_STATUS) && (byte_idx_reg >= `SFS_STAT_BYTES);
  assign rd_sec = (opcode_reg == `SFS_OP_RD_SEC) && (byte_idx_reg >= `SFS_HDR_BYTES);
  assign sec_idx = byte_idx_reg - `SFS_HDR_BYTES;
  assign sec_byte = (sec_idx >= `SFS_SEC_LEN) ? 8'h00 :
                    (sec_idx[6] ? factory_byte(sec_idx[5:0]) : otp_mem[sec_idx[5:0]]);
  assign out_byte = rd_stat ? status_w : sec_byte;

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN || cs_s_reg) begin
      SO_OUT <= 1'b0;
      SO_OE_OUT <= 1'b0;
    end else if (sck_fall) begin
      SO_OE_OUT <= rd_stat || rd_sec;
      SO_OUT <= (rd_stat || rd_sec) && out_byte[`SFS_LAST_BIT - bit_cnt_reg];
    end
  end

  // ======================================================================
  // Checks
  sequence s_page_cmd;
    cs_rise && (state_reg == SFS_ST_IDLE) && page_hdr && is_page_op;
  endsequence
  sequence s_busy_hold;
    !status_w[`SFS_ST_RDY] [*2];
  endsequence

  property p_page_start;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      s_page_cmd |=> (state_reg == SFS_ST_LOOP) && (eidx_reg == 9'h000);
  endproperty
  a_page_start: assert property (p_page_start) else $error("page op not started");
  property p_busy_flag;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      s_page_cmd |=> s_busy_hold;
  endproperty
  a_busy_flag: assert property (p_busy_flag) else $error("ready bit set while busy");
  property p_ignore_busy;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      cs_rise && busy |=> (kind_reg == $past(kind_reg)) && (page_reg == $past(page_reg));
  endproperty
  a_ignore_busy: assert property (p_ignore_busy) else $error("command taken while busy");
  property p_otp_once;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      cs_rise && !busy && otp_used_reg && (opcode_reg == `SFS_OP_PGM_SEC) |=> !busy;
  endproperty
  a_otp_once: assert property (p_otp_once) else $error("user region reprogrammed");
  property p_wrap;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      push_ok && (wr_ptr_reg == `SFS_LAST_PTR) |=> (wr_ptr_reg == 6'h00);
  endproperty
  a_wrap: assert property (p_wrap) else $error("write pointer did not wrap");
  property p_release;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      cs_s_reg |=> !SO_OE_OUT && !SO_OUT;
  endproperty
  a_release: assert property (p_release) else $error("output driven while deselected");
  property p_cmp_result;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (state_reg == SFS_ST_WAIT) && (kind_reg == SFS_K_CMP) && (timer_reg == 20'h00000)
      |=> (comp_reg == $past(mismatch_reg)) && status_w[`SFS_ST_RDY];
  endproperty
  a_cmp_result: assert property (p_cmp_result) else $error("compare result lost");
  property p_sec_first;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      sck_fall && (opcode_reg == `SFS_OP_RD_SEC) && (byte_idx_reg == `SFS_HDR_BYTES) &&
      (bit_cnt_reg == 3'h0) |=> SO_OE_OUT && (SO_OUT == otp_mem[0][7]);
  endproperty
  a_sec_first: assert property (p_sec_first) else $error("read did not start at byte 0");
  property p_loop_len;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (state_reg == SFS_ST_LOOP) && (kind_reg != SFS_K_PGM) && (eidx_reg == len - 9'h001)
      |=> (state_reg == SFS_ST_WAIT) && ($past(eidx_reg) == (ps_s_reg ? 9'h0ff : 9'h107));
  endproperty
  a_loop_len: assert property (p_loop_len) else $error("page length wrong");
endmodule

//--- test/sfs_host_model.sv
`timescale 1ns/10ps

// ======================================================================
// Host controller
// Drives the serial link in mode 0. The clock stays low outside frames.
module sfs_host_model (
  input wire logic clk_in,
  input wire logic so_in,
  output logic cs_n_out,
  output logic sck_out,
  output logic si_out
);
  int half_clks = 4;

  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
  end

  // Reply bits are sampled at the end of each high phase.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(negedge clk_in);
      sck_out = 1'b0;
      si_out = tx[i];
      repeat (half_clks) @(negedge clk_in);
      sck_out = 1'b1;
      repeat (half_clks - 1) @(negedge clk_in);
      rx[i] = so_in;
    end
  endtask

  task automatic open_frame();
    @(negedge clk_in);
    cs_n_out = 1'b0;
    repeat (half_clks) @(negedge clk_in);
  endtask

  // The data line is turned over once released, so stale bits cannot pass.
  task automatic close_frame();
    @(negedge clk_in);
    sck_out = 1'b0;
    repeat (half_clks) @(negedge clk_in);
    cs_n_out = 1'b1;
    si_out = ~si_out;
    repeat (8) @(negedge clk_in);
  endtask
endmodule

//--- test/tb_top.sv
`timescale 1ns/10ps
`include "sfs_defs.svh"

module tb_top;
  localparam int unsigned BUSY_CYC = 600;
  localparam logic [11:0] PG_A = 12'h012;
  localparam logic [11:0] PG_B = 12'h345;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic page_256 = 1'b0;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic so_last = 1'b0;
  logic so_wire;
  logic comp_exp = 1'b0;
  logic [7:0] b;
  logic [7:0] sec_exp [128];
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #50 clk_sys = ~clk_sys;

  // A released output shows the inverse of its last driven bit.
  always @(posedge clk_sys) if (so_oe) so_last <= so;
  assign so_wire = so_oe ? so : ~so_last;

  sfs_top #(.PGM_CYC(BUSY_CYC), .XFER_CYC(BUSY_CYC), .CMP_CYC(BUSY_CYC),
    .RWR_CYC(BUSY_CYC)) DUT (.CLK_SYS_IN(clk_sys), .RST_N_IN(rst_n), .CS_N_IN(cs_n),
    .SCK_IN(sck), .SI_IN(si), .PAGE_256_IN(page_256), .SO_OUT(so), .SO_OE_OUT(so_oe));

  sfs_host_model host (.clk_in(clk_sys), .so_in(so_wire), .cs_n_out(cs_n),
    .sck_out(sck), .si_out(si));

  // ======================================================================
  // Shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] op, input logic [23:0] addr);
    host.open_frame();
    host.xfer(op, b);
    for (int i = 2; i >= 0; i--) host.xfer(addr[i*8 +: 8], b);
    host.close_frame();
  endtask

  // Polls status within one frame until ready, under a bounded count.
  task automatic wait_ready(input logic busy_exp);
    logic [7:0] st;
    int n;
    n = 0;
    host.open_frame();
    host.xfer(`SFS_OP_STATUS, st);
    host.xfer(8'h00, st);
    chk({7'h00, st[7]}, {7'h00, ~busy_exp});
    while (st[7] !== 1'b1 && n < 100) begin
      host.xfer(8'h00, st);
      n++;
    end
    chk(st, {1'b1, comp_exp, 4'h9, `SFS_PROTECT, page_256});
    host.close_frame();
  endtask

  task automatic op_wait(input logic [7:0] op, input logic [23:0] addr, input logic c);
    cmd(op, addr);
    comp_exp = c;
    wait_ready(1'b1);
  endtask

  task automatic read_sec();
    host.open_frame();
    host.xfer(`SFS_OP_RD_SEC, b);
    repeat (3) host.xfer(8'h00, b);
    for (int i = 0; i < 128; i++) begin
      host.xfer(8'h00, b);
      chk(b, sec_exp[i]);
    end
    host.close_frame();
    chk({7'h00, so_oe}, 8'h00);
  endtask

  task automatic program_sec(input logic [7:0] base);
    host.open_frame();
    host.xfer(`SFS_OP_PGM_SEC, b);
    repeat (3) host.xfer(`SFS_OP_PGM_FILL, b);
    for (int i = 0; i < 66; i++) host.xfer(base + 8'(i), b);
    host.close_frame();
  endtask

  // ======================================================================
  // Scenarios
  task automatic t_status();
    host.half_clks = 6;
    wait_ready(1'b0);
    @(negedge clk_sys);
    page_256 = 1'b1;
    wait_ready(1'b0);
    @(negedge clk_sys);
    page_256 = 1'b0;
    host.half_clks = 4;
  endtask

  task automatic t_sec_fresh();
    for (int i = 0; i < 128; i++) begin
      sec_exp[i] = (i < 64) ? `SFS_ERASED : (8'(i - 64) ^ `SFS_UID_SEED);
    end
    read_sec();
  endtask

  task automatic t_page_ops();
    op_wait(`SFS_OP_XFER1, {3'h7, PG_A, 9'h1ff}, 1'b0);
    op_wait(`SFS_OP_CMP1, {3'h0, PG_A, 9'h000}, 1'b0);
    op_wait(`SFS_OP_XFER2, {3'h5, PG_B, 9'h0a5}, 1'b0);
    op_wait(`SFS_OP_CMP2, {3'h0, PG_A, 9'h000}, 1'b1);
    op_wait(`SFS_OP_CMP2, {3'h0, PG_B, 9'h000}, 1'b0);
  endtask

  task automatic t_program();
    program_sec(8'h20);
    wait_ready(1'b1);
    for (int i = 0; i < 64; i++) sec_exp[i] = 8'h20 + 8'(i);
    sec_exp[0] = 8'h60;
    sec_exp[1] = 8'h61;
    read_sec();
    op_wait(`SFS_OP_CMP1, {3'h0, PG_A, 9'h000}, 1'b1);
    program_sec(8'h90);
    wait_ready(1'b0);
    read_sec();
  endtask

  task automatic t_rewrite();
    cmd(`SFS_OP_RWR1, {3'h0, PG_A, 9'h000});
    cmd(`SFS_OP_XFER2, {3'h0, PG_A, 9'h000});
    wait_ready(1'b1);
    op_wait(`SFS_OP_CMP1, {3'h0, PG_A, 9'h000}, 1'b0);
    op_wait(`SFS_OP_CMP2, {3'h0, PG_B, 9'h000}, 1'b0);
    op_wait(`SFS_OP_RWR2, {3'h0, PG_B, 9'h000}, 1'b0);
    op_wait(`SFS_OP_CMP2, {3'h0, PG_B, 9'h000}, 1'b0);
  endtask

  task automatic t_bin_page();
    @(negedge clk_sys);
    page_256 = 1'b1;
    op_wait(`SFS_OP_XFER1, {4'hf, PG_A, 8'hff}, 1'b0);
    op_wait(`SFS_OP_CMP1, {4'h0, PG_A, 8'h00}, 1'b0);
    op_wait(`SFS_OP_CMP1, {4'h0, PG_A ^ 12'h001, 8'h00}, 1'b1);
  endtask

  // ======================================================================
  // Run control
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (5) @(negedge clk_sys);
    t_status();
    t_sec_fresh();
    t_page_ops();
    t_program();
    t_rewrite();
    t_bin_page();
    final_report();
  end
endmodule
